// ===== hw/cfi_query_pkg.sv
// package of constants for the query-database read-out path
// assumes a 16-bit word-addressed parallel flash bus
package cfi_query_pkg;
   // bus widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   // commands on the low byte of a write
   localparam logic [7:0] CMD_QUERY_READ = 8'h98;
   localparam logic [7:0] CMD_ARRAY_READ = 8'hFF;
   localparam logic [7:0] CMD_ID_READ = 8'h90;
   localparam logic [7:0] CMD_STATUS_READ = 8'h70;
   // database word addresses
   localparam logic [7:0] ADDR_RSVD_LO = 8'h01;
   localparam logic [7:0] ADDR_RSVD_HI = 8'h0F;
   localparam logic [7:0] ADDR_Q = 8'h10;
   localparam logic [7:0] ADDR_R = 8'h11;
   localparam logic [7:0] ADDR_Y = 8'h12;
   localparam logic [7:0] ADDR_PID_LO = 8'h13;
   localparam logic [7:0] ADDR_PID_HI = 8'h14;
   localparam logic [7:0] ADDR_PTR_LO = 8'h15;
   localparam logic [7:0] ADDR_PTR_HI = 8'h16;
   localparam logic [7:0] ADDR_AID_LO = 8'h17;
   localparam logic [7:0] ADDR_AID_HI = 8'h18;
   // database contents
   localparam logic [7:0] CHAR_Q = 8'h51;
   localparam logic [7:0] CHAR_R = 8'h52;
   localparam logic [7:0] CHAR_Y = 8'h59;
   localparam logic [15:0] PRIMARY_ID = 16'h0200;
   localparam logic [15:0] PRIMARY_TABLE_PTR = 16'h010A;
   localparam logic [15:0] ALTERNATE_ID = 16'h0000;
   localparam logic [7:0] UPPER_BYTE = 8'h00;
   // program buffer depth in words
   localparam int PROG_BUF_WORDS = 512;
   // read modes
   typedef enum logic [1:0] {
      MODE_ARRAY = 2'b00,
      MODE_QUERY = 2'b01,
      MODE_OTHER = 2'b11
   } read_mode_t;
endpackage

// ===== hw/cfi_query_rom.sv
// database lookup table for query reads
// assumes a registered word address from the bus front end
module cfi_query_rom (
   // lookup
   input wire logic [7:0] wordAddr,
   output logic [7:0] lowByte
);
   // [RL4] [RL6] word offsets, identification section from 10h
   always_comb begin
      lowByte = 8'h00;
      unique case (wordAddr)
         // [RL5] QRY string
         cfi_query_pkg::ADDR_Q: lowByte = cfi_query_pkg::CHAR_Q;
         cfi_query_pkg::ADDR_R: lowByte = cfi_query_pkg::CHAR_R;
         cfi_query_pkg::ADDR_Y: lowByte = cfi_query_pkg::CHAR_Y;
         // [RL12] primary identifier bytes
         cfi_query_pkg::ADDR_PID_LO: lowByte = cfi_query_pkg::PRIMARY_ID[7:0];
         cfi_query_pkg::ADDR_PID_HI: lowByte = cfi_query_pkg::PRIMARY_ID[15:8];
         // [RL8] [RL9] table pointer bytes
         cfi_query_pkg::ADDR_PTR_LO: lowByte = cfi_query_pkg::PRIMARY_TABLE_PTR[7:0];
         cfi_query_pkg::ADDR_PTR_HI: lowByte = cfi_query_pkg::PRIMARY_TABLE_PTR[15:8];
         // [RL13] no alternate algorithm
         cfi_query_pkg::ADDR_AID_LO: lowByte = cfi_query_pkg::ALTERNATE_ID[7:0];
         cfi_query_pkg::ADDR_AID_HI: lowByte = cfi_query_pkg::ALTERNATE_ID[15:8];
         // [RL7] vendor area and unlisted offsets read zero
         default: lowByte = 8'h00;
      endcase
   end
endmodule

// ===== hw/flash_cfi_query_readout.sv
// query-database read-out path of a 16-bit flash bus front end
// assumes bus inputs synchronous to clk and an external array read path
//
// What this block does
// [RL1] a query-read command switches reads from the array to the database.
// [RL2] every database byte comes out on the low eight data lines.
// [RL3] the high eight data lines read zero for every database location.
// [RL4] offsets are word addresses with the identification string at 10h.
// [RL5] word addresses 10h, 11h and 12h return Q, R and Y.
// [RL6] the identification section at 010h holds command-set id and table offset.
// [RL7] word addresses 01h to 0Fh are vendor reserved and read zero here.
// [RL8] the extended table pointer is low byte at 15h and high byte at 16h.
// [RL9] the primary extended table lives at the address the pointer gives; this block holds no such table, and 010Ah lies beyond its 8-bit word address.
// [RL10] an address-valid strobe held low after a write starts a new read.
// [RL11] the program buffer holds up to 512 words per buffered program; this block has no buffer and only reports BUF_WORDS on progBufLimit.
// [RL12] the primary command-set id sits at 13h and 14h, low byte first.
// [RL13] the alternate command-set id at 17h and 18h reads zero.
// [RL14] query-read mode lasts until another read-mode command is written.
module flash_cfi_query_readout #(
   parameter int BUF_WORDS = cfi_query_pkg::PROG_BUF_WORDS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // flash bus
   input wire logic chipEnable_n,
   input wire logic writeEnable_n,
   input wire logic outputEnable_n,
   input wire logic address_valid_strobe_n,
   input wire logic [cfi_query_pkg::ADDR_W-1:0] addrIn,
   input wire logic [cfi_query_pkg::DATA_W-1:0] dataIn,
   output logic [cfi_query_pkg::DATA_W-1:0] dataOut,
   output logic dataOutEnable,
   // array read path
   input wire logic [cfi_query_pkg::DATA_W-1:0] arrayData,
   output logic [cfi_query_pkg::ADDR_W-1:0] arrayAddr,
   // status
   output logic queryMode,
   output logic readStart,
   output logic [$clog2(BUF_WORDS+1)-1:0] progBufLimit
);
   cfi_query_pkg::read_mode_t mode_reg, mode_next;
   logic [7:0] addr_reg, addr_next;
   logic weDly_reg, weDly_next;
   logic [15:0] data_reg, data_next;
   logic oe_reg, oe_next;
   logic rs_reg, rs_next;
   logic [7:0] romByte;
   logic writeEnd;

   cfi_query_rom rom (
      .wordAddr(addr_reg),
      .lowByte(romByte)
   );

   assign writeEnd = weDly_reg == 1'b0 && writeEnable_n == 1'b1 && chipEnable_n == 1'b0;

   always_comb begin
      mode_next = mode_reg;
      addr_next = addr_reg;
      weDly_next = writeEnable_n;
      rs_next = 1'b0;
      // latch address while strobe is low
      if (!address_valid_strobe_n && !chipEnable_n) begin
         addr_next = addrIn;
      end
      // [RL1] command decode at write end
      if (writeEnd) begin
         unique case (dataIn[7:0])
            cfi_query_pkg::CMD_QUERY_READ: mode_next = cfi_query_pkg::MODE_QUERY;
            cfi_query_pkg::CMD_ARRAY_READ: mode_next = cfi_query_pkg::MODE_ARRAY;
            // [RL14] other read modes leave query mode
            cfi_query_pkg::CMD_ID_READ,
            cfi_query_pkg::CMD_STATUS_READ: mode_next = cfi_query_pkg::MODE_OTHER;
            default: mode_next = mode_reg;
         endcase
         // [RL10] strobe still low starts a read
         if (!address_valid_strobe_n) begin
            rs_next = 1'b1;
         end
      end
   end

   always_comb begin
      oe_next = !chipEnable_n && !outputEnable_n && writeEnable_n;
      data_next = arrayData;
      if (mode_reg == cfi_query_pkg::MODE_QUERY) begin
         // [RL2] [RL3] low byte data, high byte zero
         data_next = {cfi_query_pkg::UPPER_BYTE, romByte};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_reg <= cfi_query_pkg::MODE_ARRAY;
         addr_reg <= 8'h00;
         weDly_reg <= 1'b1;
         rs_reg <= 1'b0;
         data_reg <= 16'h0000;
         oe_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         addr_reg <= addr_next;
         weDly_reg <= weDly_next;
         rs_reg <= rs_next;
         data_reg <= data_next;
         oe_reg <= oe_next;
      end
   end

   assign dataOut = data_reg;
   assign dataOutEnable = oe_reg;
   assign arrayAddr = addr_reg;
   assign queryMode = mode_reg == cfi_query_pkg::MODE_QUERY;
   assign readStart = rs_reg;
   // [RL11] buffer depth advertised
   assign progBufLimit = ($clog2(BUF_WORDS+1))'(BUF_WORDS);
endmodule

// ===== tb/cfi_query_monitor.sv
// assertions on the query read-out ports
// assumes a bind onto flash_cfi_query_readout
module cfi_query_monitor #(parameter int BUF_WORDS = 512) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus inputs
   input wire logic chipEnable_n,
   input wire logic writeEnable_n,
   input wire logic address_valid_strobe_n,
   input wire logic [15:0] dataIn,
   // outputs
   input wire logic [15:0] dataOut,
   input wire logic [7:0] arrayAddr,
   input wire logic queryMode,
   input wire logic readStart,
   input wire logic [$clog2(BUF_WORDS+1)-1:0] progBufLimit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic weReg;
   logic take;
   always_ff @(posedge clk) weReg <= writeEnable_n;
   // a write ends on the first high sample of the enable
   assign take = writeEnable_n && !weReg && !chipEnable_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence inQ; queryMode && $past(queryMode, 3); endsequence
   property rom(logic [7:0] a, logic [7:0] v); inQ ##0 $past(arrayAddr) == a |-> dataOut == {8'h00, v}; endproperty
   a_enter_query: assert property (take && dataIn[7:0] == 8'h98 |-> ##[1:2] queryMode) else $error("no query mode");
   a_leave_query: assert property (take && dataIn[7:0] == 8'hFF |-> ##[1:2] !queryMode) else $error("query kept");
   a_mode_cause: assert property ($changed(queryMode) |-> $past(take) || $past(take, 2)) else $error("mode moved");
   a_upper_zero: assert property (inQ |-> dataOut[15:8] == 8'h00) else $error("upper byte set");
   a_char_q: assert property (rom(8'h10, 8'h51)) else $error("bad Q");
   a_char_y: assert property (rom(8'h12, 8'h59)) else $error("bad Y");
   a_pid_low: assert property (rom(8'h13, cfi_query_pkg::PRIMARY_ID[7:0])) else $error("bad id low");
   a_ptr_low: assert property (rom(8'h15, cfi_query_pkg::PRIMARY_TABLE_PTR[7:0])) else $error("bad ptr low");
   a_ptr_high: assert property (rom(8'h16, cfi_query_pkg::PRIMARY_TABLE_PTR[15:8])) else $error("bad ptr");
   a_alt_zero: assert property (rom(8'h18, 8'h00)) else $error("alt id set");
   a_rsvd_zero: assert property (rom(8'h0F, 8'h00)) else $error("reserved set");
   a_read_start: assert property (take && !address_valid_strobe_n |-> ##[1:2] readStart) else $error("no read");
   a_buf_depth: assert property (progBufLimit == BUF_WORDS) else $error("bad depth");
endmodule

// ===== tb/flash_host.sv
// behavioural host on the flash bus
// assumes the bench calls its tasks; drives just after rising edges
module flash_host (
   // clock and read data
   input wire logic clk,
   input wire logic [15:0] dout,
   // bus
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic adv_n,
   output logic [7:0] addr,
   output logic [15:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {ce_n, we_n, oe_n, adv_n, addr, data} = 28'hF000000;
   // command write, strobe optionally held low
   task automatic wr(input logic [7:0] c, input logic adv);
      @(posedge clk);
      {ce_n, we_n, oe_n, adv_n, data} <= {3'b001, adv, 8'h00, c};
      @(posedge clk);
      we_n <= 1'b1;
      @(posedge clk);
      // released lines show the inverse so stale data never passes
      {ce_n, adv_n, data} <= {2'b11, ~data};
   endtask
   // word-addressed read, bus held until the next operation
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge clk);
      {ce_n, oe_n, adv_n, addr} <= {3'b000, a};
      repeat (3) @(posedge clk);
      #1 q = dout;
   endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the query read-out path
// assumes flash_host drives the bus and the monitor is bound below
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce_n, we_n, oe_n, adv_n, rs, qm, oen;
   logic [7:0] addr, aa;
   logic [15:0] data, dout, q;
   logic [9:0] lim;
   int errors = 0;
   int compares = 0;
   always #2 clk = ~clk;
   flash_host host (.clk(clk), .dout(dout), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .adv_n(adv_n), .addr(addr),
      .data(data));
   flash_cfi_query_readout dut (.clk(clk), .rst_n(rst_n), .chipEnable_n(ce_n), .writeEnable_n(we_n),
      .outputEnable_n(oe_n), .address_valid_strobe_n(adv_n), .addrIn(addr), .dataIn(data), .dataOut(dout),
      .dataOutEnable(oen), .arrayData(16'hA5C3), .arrayAddr(aa), .queryMode(qm), .readStart(rs), .progBufLimit(lim));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic mode(input logic [7:0] c, input logic exp);
      host.wr(c, 1'b1);
      repeat (2) @(posedge clk);
      #1 chk(16'(qm), 16'(exp));
   endtask
   task automatic t_array;
      host.rd(8'h20, q);
      chk(q, 16'hA5C3);
      chk(16'(oen), 16'h0001);
      chk(16'(aa), 16'h0020);
      chk(16'(lim), 16'h0200);
   endtask
   task automatic t_table;
      logic [7:0] ta [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h01, 8'h0F};
      logic [7:0] tv [11] = '{8'h51, 8'h52, 8'h59, cfi_query_pkg::PRIMARY_ID[7:0], cfi_query_pkg::PRIMARY_ID[15:8],
         cfi_query_pkg::PRIMARY_TABLE_PTR[7:0], cfi_query_pkg::PRIMARY_TABLE_PTR[15:8], 8'h00, 8'h00, 8'h00, 8'h00};
      mode(8'h98, 1'b1);
      foreach (ta[i]) begin
         host.rd(ta[i], q);
         chk(q, {8'h00, tv[i]});
      end
   endtask
   task automatic t_modes;
      // unknown command with strobe low keeps the mode and starts a read
      host.wr(8'h55, 1'b0);
      #1 chk(16'(rs), 16'h0001);
      mode(8'h55, 1'b1);
      chk(16'(rs), 16'h0000);
      mode(8'h90, 1'b0);
      mode(8'h98, 1'b1);
      mode(8'h70, 1'b0);
      mode(8'h98, 1'b1);
      mode(8'hFF, 1'b0);
   endtask
   task automatic give_verdict;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_array;
      t_table;
      t_modes;
      give_verdict;
   end
endmodule
bind flash_cfi_query_readout cfi_query_monitor #(.BUF_WORDS(BUF_WORDS)) mon (.clk(clk), .rst_n(rst_n),
   .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n), .address_valid_strobe_n(address_valid_strobe_n),
   .dataIn(dataIn), .dataOut(dataOut), .arrayAddr(arrayAddr), .queryMode(queryMode), .readStart(readStart),
   .progBufLimit(progBufLimit));
